// file: hdl/exu_pkg.sv
// Purpose: shared constants for the exception priority and interrupt front end
// Assumes: single core clock, synchronous active-low reset
// Notes: cause codes follow the priority order, zero is highest
package exu_pkg;
    localparam int EXU_HW_IRQS = 6;
    localparam int EXU_SW_IRQS = 2;
    localparam int EXU_IRQS = 9;
    localparam int EXU_SHADOW_W = 2;
    localparam int EXU_VEC_W = 4;
    // entries of the priority list, reset down to load data break
    localparam int EXU_NCAUSE = 34;
    localparam logic [1:0] EXU_VECTORED_MODE_PRESENT_BIT_PRESENT = 2'h1;

    typedef enum logic [1:0] {
        EXU_MODE_COMPAT = 2'b00,
        EXU_MODE_VECTORED = 2'b01,
        EXU_MODE_EXTERNAL = 2'b10
    } exu_mode_e;

    typedef enum logic [5:0] {
        EXU_C_RESET = 6'h00,
        EXU_C_DSS = 6'h01,
        EXU_C_DINT = 6'h02,
        EXU_C_NMI = 6'h03,
        EXU_C_MCHECK = 6'h04,
        EXU_C_INT = 6'h05,
        EXU_C_DEF_WATCH = 6'h06,
        EXU_C_IBRK = 6'h07,
        EXU_C_IWATCH = 6'h08,
        EXU_C_FETCH_ALIGN = 6'h09,
        EXU_C_FETCH_PROT = 6'h0A,
        EXU_C_FETCH_MISS = 6'h0B,
        EXU_C_FETCH_INV = 6'h0C,
        EXU_C_FETCH_BUS = 6'h0D,
        EXU_C_DBG_BRK = 6'h0E,
        EXU_C_SYSTRAP = 6'h0F,
        EXU_C_BREAK = 6'h10,
        EXU_C_RSVD = 6'h11,
        EXU_C_COP_UNUSE = 6'h12,
        EXU_C_OVF = 6'h13,
        EXU_C_TRAP = 6'h14,
        EXU_C_DADDR_BRK = 6'h15,
        EXU_C_DWATCH = 6'h16,
        EXU_C_LD_ALIGN = 6'h17,
        EXU_C_LD_PROT = 6'h18,
        EXU_C_ST_ALIGN = 6'h19,
        EXU_C_ST_PROT = 6'h1A,
        EXU_C_LD_MISS = 6'h1B,
        EXU_C_LD_INV = 6'h1C,
        EXU_C_ST_MISS = 6'h1D,
        EXU_C_ST_INV = 6'h1E,
        EXU_C_WPROT = 6'h1F,
        EXU_C_DBUS = 6'h20,
        EXU_C_LD_DATA_BRK = 6'h21,
        EXU_C_NONE = 6'h3F
    } exu_cause_e;
endpackage

// file: hdl/exu_core.sv
// Purpose: exception recognition, priority select and interrupt mode front end
// Assumes: condition inputs are synchronous to mclk and sampled every cycle
// Notes: one registered decision per cycle; pipeline flush is outside this block
`timescale 1ns/1ps
module exu_core
    import exu_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic dbg_single_step,
    input wire logic dbg_interrupt,
    input wire logic nmi,
    input wire logic machine_check,
    input wire logic [EXU_HW_IRQS-1:0] hw_irq,
    input wire logic [EXU_SW_IRQS-1:0] sw_irq,
    input wire logic timer_irq,
    input wire logic [EXU_IRQS-1:0] irq_mask,
    input wire logic irq_global_en,
    input wire logic [1:0] irq_mode_sel,
    input wire logic mode_wr,
    input wire logic [EXU_SHADOW_W-1:0] srs_map [EXU_IRQS],
    input wire logic [EXU_VEC_W-1:0] ext_vector,
    input wire logic [EXU_SHADOW_W-1:0] ext_shadow,
    input wire logic ext_irq_req,
    input wire logic ext_ctrl_present_strap,
    input wire logic watch_masked,
    input wire logic instr_hw_break_match,
    input wire logic fetch_watch_match,
    input wire logic fetch_misaligned,
    input wire logic fetch_protected,
    input wire logic fetch_tlb_miss,
    input wire logic fetch_tlb_invalid,
    input wire logic fetch_bus_err,
    input wire logic debug_break_instruction,
    input wire logic system_trap_instruction,
    input wire logic break_instr,
    input wire logic reserved_opcode,
    input wire logic cop_unusable,
    input wire logic arith_overflow,
    input wire logic trap_true,
    input wire logic data_addr_break,
    input wire logic store_value_break,
    input wire logic data_watch_match,
    input wire logic is_load,
    input wire logic is_store,
    input wire logic data_misaligned,
    input wire logic data_protected,
    input wire logic data_tlb_miss,
    input wire logic data_tlb_invalid,
    input wire logic data_tlb_dirty,
    input wire logic data_bus_err,
    input wire logic load_data_break,
    output logic exc_valid,
    output exu_cause_e exc_cause,
    output logic irq_vectored,
    output logic [EXU_VEC_W-1:0] irq_vector,
    output logic [EXU_SHADOW_W-1:0] irq_shadow,
    output exu_mode_e irq_mode,
    output logic watch_deferred,
    output logic vectored_mode_present_bit,
    output logic ext_ctrl_mode_present_bit
);
    // ----------------------------------------
    // condition vector
    // ----------------------------------------
    logic [EXU_NCAUSE-1:0] pend;
    logic [EXU_IRQS-1:0] irq_raw;
    logic [EXU_IRQS-1:0] irq_act;
    logic int_pending;

    assign irq_raw = {hw_irq, timer_irq, sw_irq};
    assign irq_act = irq_raw & irq_mask;
    assign int_pending = irq_global_en &&
        ((irq_mode == EXU_MODE_EXTERNAL) ? ext_irq_req : (|irq_act));

    always_comb begin
        pend = '0;
        pend[EXU_C_RESET] = 1'b0;
        pend[EXU_C_DSS] = dbg_single_step;
        pend[EXU_C_DINT] = dbg_interrupt;
        pend[EXU_C_NMI] = nmi;
        pend[EXU_C_MCHECK] = machine_check;
        pend[EXU_C_INT] = int_pending;
        pend[EXU_C_DEF_WATCH] = watch_deferred && !watch_masked;
        pend[EXU_C_IBRK] = instr_hw_break_match;
        pend[EXU_C_IWATCH] = fetch_watch_match && !watch_masked;
        pend[EXU_C_FETCH_ALIGN] = fetch_misaligned;
        pend[EXU_C_FETCH_PROT] = fetch_protected;
        pend[EXU_C_FETCH_MISS] = fetch_tlb_miss;
        pend[EXU_C_FETCH_INV] = fetch_tlb_invalid;
        pend[EXU_C_FETCH_BUS] = fetch_bus_err;
        pend[EXU_C_DBG_BRK] = debug_break_instruction;
        pend[EXU_C_SYSTRAP] = system_trap_instruction;
        pend[EXU_C_BREAK] = break_instr;
        pend[EXU_C_RSVD] = reserved_opcode;
        pend[EXU_C_COP_UNUSE] = cop_unusable;
        pend[EXU_C_OVF] = arith_overflow;
        pend[EXU_C_TRAP] = trap_true;
        pend[EXU_C_DADDR_BRK] = data_addr_break || (is_store && store_value_break);
        pend[EXU_C_DWATCH] = data_watch_match && !watch_masked;
        pend[EXU_C_LD_ALIGN] = is_load && data_misaligned;
        pend[EXU_C_LD_PROT] = is_load && data_protected;
        pend[EXU_C_ST_ALIGN] = is_store && data_misaligned;
        pend[EXU_C_ST_PROT] = is_store && data_protected;
        pend[EXU_C_LD_MISS] = is_load && data_tlb_miss;
        pend[EXU_C_LD_INV] = is_load && !data_tlb_miss && data_tlb_invalid;
        pend[EXU_C_ST_MISS] = is_store && data_tlb_miss;
        pend[EXU_C_ST_INV] = is_store && !data_tlb_miss && data_tlb_invalid;
        pend[EXU_C_WPROT] = is_store && !data_tlb_miss && !data_tlb_invalid &&
            !data_tlb_dirty;
        pend[EXU_C_DBUS] = data_bus_err && (is_load || is_store);
        pend[EXU_C_LD_DATA_BRK] = is_load && load_data_break;
    end

    // ----------------------------------------
    // priority select
    // ----------------------------------------
    exu_cause_e win;
    logic win_valid;

    always_comb begin
        win = EXU_C_NONE;
        win_valid = 1'b0;
        for (int i = EXU_NCAUSE - 1; i >= 0; i--) begin
            if (pend[i]) begin
                win = exu_cause_e'(6'(i));
                win_valid = 1'b1;
            end
        end
    end

    // ----------------------------------------
    // interrupt vector and shadow select
    // ----------------------------------------
    logic [EXU_VEC_W-1:0] vi_vec;
    logic [EXU_SHADOW_W-1:0] vi_shadow;

    // highest numbered source wins; fixed order keeps the select flat
    always_comb begin
        vi_vec = '0;
        vi_shadow = '0;
        for (int i = 0; i < EXU_IRQS; i++) begin
            if (irq_act[i]) begin
                vi_vec = EXU_VEC_W'(i);
                vi_shadow = srs_map[i];
            end
        end
    end

    // ----------------------------------------
    // state registers
    // ----------------------------------------
    exu_mode_e next_irq_mode;
    logic next_watch_deferred;
    logic next_exc_valid;
    exu_cause_e next_exc_cause;
    logic next_irq_vectored;
    logic [EXU_VEC_W-1:0] next_irq_vector;
    logic [EXU_SHADOW_W-1:0] next_irq_shadow;

    always_comb begin
        next_irq_mode = irq_mode;
        if (mode_wr) begin
            if (irq_mode_sel == EXU_MODE_VECTORED) begin
                next_irq_mode = EXU_MODE_VECTORED;
            end else if (irq_mode_sel == EXU_MODE_EXTERNAL && ext_ctrl_present_strap) begin
                next_irq_mode = EXU_MODE_EXTERNAL;
            end else if (irq_mode_sel == EXU_MODE_COMPAT) begin
                next_irq_mode = EXU_MODE_COMPAT;
            end
        end
        // hold masked watch, set wins over release
        next_watch_deferred = watch_deferred;
        if (watch_masked && (fetch_watch_match || data_watch_match)) begin
            next_watch_deferred = 1'b1;
        end else if (!watch_masked && win == EXU_C_DEF_WATCH) begin
            next_watch_deferred = 1'b0;
        end
        next_exc_valid = win_valid;
        next_exc_cause = win;
        next_irq_vectored = 1'b0;
        next_irq_vector = '0;
        next_irq_shadow = '0;
        if (win == EXU_C_INT) begin
            // shadow per vector in vectored and external modes
            unique case (irq_mode)
                EXU_MODE_COMPAT: begin
                    next_irq_vectored = 1'b0;
                end
                EXU_MODE_VECTORED: begin
                    next_irq_vectored = 1'b1;
                    next_irq_vector = vi_vec;
                    next_irq_shadow = vi_shadow;
                end
                EXU_MODE_EXTERNAL: begin
                    next_irq_vectored = 1'b1;
                    next_irq_vector = ext_vector;
                    next_irq_shadow = ext_shadow;
                end
                default: begin
                    next_irq_vectored = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            irq_mode <= EXU_MODE_COMPAT;
            watch_deferred <= 1'b0;
            // reset itself is the top cause, reported while held
            exc_valid <= 1'b1;
            exc_cause <= EXU_C_RESET;
            irq_vectored <= 1'b0;
            irq_vector <= '0;
            irq_shadow <= '0;
        end else begin
            irq_mode <= next_irq_mode;
            watch_deferred <= next_watch_deferred;
            exc_valid <= next_exc_valid;
            exc_cause <= next_exc_cause;
            irq_vectored <= next_irq_vectored;
            irq_vector <= next_irq_vector;
            irq_shadow <= next_irq_shadow;
        end
    end

    assign vectored_mode_present_bit = EXU_VECTORED_MODE_PRESENT_BIT_PRESENT[0];
    assign ext_ctrl_mode_present_bit = ext_ctrl_present_strap;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    sequence s_masked_watch;
        watch_masked && fetch_watch_match;
    endsequence
    sequence s_unmask;
        !watch_masked;
    endsequence

    chk_nmi_beats_int: assert property (nmi && !dbg_single_step && !dbg_interrupt
        |=> exc_cause == EXU_C_NMI)
        else $error("nmi not taken over lower causes");
    chk_watch_defer: assert property (s_masked_watch |=> watch_deferred)
        else $error("masked watch not deferred");
    chk_watch_release: assert property (watch_deferred && !watch_masked && !dbg_single_step
        && !dbg_interrupt && !nmi && !machine_check && !int_pending
        |=> exc_cause == EXU_C_DEF_WATCH)
        else $error("deferred watch not raised on unmask");
    chk_ibrk_raise: assert property (instr_hw_break_match |=> exc_valid &&
        exc_cause <= EXU_C_IBRK)
        else $error("instruction break lost");
    chk_fetch_align: assert property (fetch_misaligned |=> exc_cause <= EXU_C_FETCH_ALIGN)
        else $error("fetch alignment lost");
    chk_system_trap_instruction_cause: assert property (system_trap_instruction && pend[14:0] == '0
        |=> exc_cause == EXU_C_SYSTRAP)
        else $error("system trap cause wrong");
    chk_wprot: assert property (is_store && !data_tlb_miss && !data_tlb_invalid &&
        !data_tlb_dirty |=> exc_valid && exc_cause <= EXU_C_WPROT)
        else $error("write protect lost");
    chk_ld_break_last: assert property (exc_cause == EXU_C_LD_DATA_BRK |->
        $past(pend[32:0]) == '0)
        else $error("load data break not lowest");
    chk_vectored_mode_present_bit_one: assert property (vectored_mode_present_bit)
        else $error("vectored capability bit low");
    chk_reset_mode: assert property ($rose(nrst) |-> irq_mode == EXU_MODE_COMPAT)
        else $error("mode not compat after reset");
    chk_vi_shadow: assert property (irq_mode == EXU_MODE_VECTORED && win == EXU_C_INT
        |=> irq_vectored && irq_shadow == $past(vi_shadow))
        else $error("vectored shadow not applied");
endmodule

// file: test/exu_eic_model.sv
// Purpose: far-side model, external interrupt controller and its strap
// Assumes: bench chooses which request the controller presents
// Notes: a released vector bus shows the inverse of its last value
`timescale 1ns/1ps
module exu_eic_model (
    input wire logic mclk,
    input wire logic fitted,
    input wire logic raise,
    input wire logic [3:0] vec,
    input wire logic [1:0] shd,
    output logic ext_irq_req,
    output logic [3:0] ext_vector,
    output logic [1:0] ext_shadow,
    output logic ext_ctrl_present_strap
);
    logic [3:0] last_vec = 4'h0;
    logic [1:0] last_shd = 2'h0;
    // ----------------------------------------
    // controller outputs
    // ----------------------------------------
    // static strap
    assign ext_ctrl_present_strap = fitted;
    assign ext_irq_req = raise;
    assign ext_vector = raise ? vec : ~last_vec;
    assign ext_shadow = raise ? shd : ~last_shd;
    always_ff @(posedge mclk) begin
        if (raise) begin
            last_vec <= vec;
            last_shd <= shd;
        end
    end
endmodule

// file: test/tb_top.sv
// Purpose: self-checking bench for exception priority and interrupt modes
// Assumes: decisions land one edge after the inputs are presented
// Notes: each cause on the cond vector is checked alone and with every lower-priority cond bit pending
`timescale 1ns/1ps
module tb_top
    import exu_pkg::*;
;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic [26:0] cond = 27'h0;
    logic ld = 1'b0, st = 1'b0, dty = 1'b1, wm = 1'b0;
    logic [5:0] hw = 6'h0;
    logic [1:0] sw = 2'h0, sel = 2'h0, eshd = 2'h0;
    logic tm = 1'b0, gen = 1'b0, mwr = 1'b0, raise = 1'b0, strap = 1'b0;
    logic [8:0] msk = 9'h0;
    logic [3:0] evec = 4'h0;
    logic [1:0] srs [EXU_IRQS];
    logic ereq, estrap, exc_valid, irq_vectored, watch_deferred, vbit, ebit;
    logic [3:0] evec_w, irq_vector;
    logic [1:0] eshd_w, irq_shadow;
    exu_cause_e exc_cause;
    exu_mode_e irq_mode;
    int failures = 0, checked = 0;

    exu_eic_model eic (.mclk(mclk), .fitted(strap), .raise(raise), .vec(evec), .shd(eshd),
        .ext_irq_req(ereq), .ext_vector(evec_w), .ext_shadow(eshd_w),
        .ext_ctrl_present_strap(estrap));
    exu_core uut (.mclk(mclk), .nrst(nrst), .dbg_single_step(cond[0]),
        .dbg_interrupt(cond[1]), .nmi(cond[2]), .machine_check(cond[3]), .hw_irq(hw),
        .sw_irq(sw), .timer_irq(tm), .irq_mask(msk), .irq_global_en(gen),
        .irq_mode_sel(sel), .mode_wr(mwr), .srs_map(srs), .ext_vector(evec_w),
        .ext_shadow(eshd_w), .ext_irq_req(ereq), .ext_ctrl_present_strap(estrap),
        .watch_masked(wm), .instr_hw_break_match(cond[4]), .fetch_watch_match(cond[5]),
        .fetch_misaligned(cond[6]), .fetch_protected(cond[7]), .fetch_tlb_miss(cond[8]),
        .fetch_tlb_invalid(cond[9]), .fetch_bus_err(cond[10]),
        .debug_break_instruction(cond[11]), .system_trap_instruction(cond[12]),
        .break_instr(cond[13]), .reserved_opcode(cond[14]), .cop_unusable(cond[15]),
        .arith_overflow(cond[16]), .trap_true(cond[17]), .data_addr_break(cond[18]),
        .store_value_break(cond[19]), .data_watch_match(cond[20]), .is_load(ld),
        .is_store(st), .data_misaligned(cond[21]), .data_protected(cond[22]),
        .data_tlb_miss(cond[23]), .data_tlb_invalid(cond[24]), .data_tlb_dirty(dty),
        .data_bus_err(cond[25]), .load_data_break(cond[26]), .exc_valid(exc_valid),
        .exc_cause(exc_cause), .irq_vectored(irq_vectored), .irq_vector(irq_vector),
        .irq_shadow(irq_shadow), .irq_mode(irq_mode), .watch_deferred(watch_deferred),
        .vectored_mode_present_bit(vbit), .ext_ctrl_mode_present_bit(ebit));

    always #4 mclk = ~mclk;
    initial for (int i = 0; i < EXU_IRQS; i++) srs[i] = 2'(i + 1);

    task summarize();
        $display("counts: checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task go();
        @(posedge mclk);
        #1;
    endtask
    task cmp_cause(input exu_cause_e exp);
        checked++;
        if (exc_cause !== exp || exc_valid !== (exp != EXU_C_NONE)) begin
            failures++;
            $display("mismatch t=%0t got %h exp %h", $time, exc_cause, exp);
        end
    endtask
    task cmp_val(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // cause alone, then with every lower-priority condition pending too
    task one(input int k, input logic l, input logic s, input logic d, input exu_cause_e c);
        @(posedge mclk);
        cond <= 27'h1 << k;
        ld <= l;
        st <= s;
        dty <= d;
        go();
        cmp_cause(c);
        @(posedge mclk);
        cond <= ~27'h0 << k;
        go();
        cmp_cause(c);
    endtask
    task irq(input logic [1:0] s, input logic t, input logic [5:0] h, input exu_cause_e c,
        input logic [7:0] v);
        @(posedge mclk);
        sw <= s;
        tm <= t;
        hw <= h;
        go();
        cmp_cause(c);
        if (c == EXU_C_INT)
            cmp_val({1'b0, irq_vectored, irq_shadow, irq_vector}, v);
    endtask
    task set_mode(input logic [1:0] m, input exu_mode_e e);
        @(posedge mclk);
        mwr <= 1'b1;
        sel <= m;
        @(posedge mclk);
        mwr <= 1'b0;
        #1;
        cmp_val({6'h0, irq_mode}, {6'h0, e});
    endtask
    task do_reset(input logic sp);
        @(posedge mclk);
        nrst <= 1'b0;
        strap <= sp;
        repeat (3) @(posedge mclk);
        #1;
        cmp_cause(EXU_C_RESET);
        cmp_val({6'h0, irq_mode}, {6'h0, EXU_MODE_COMPAT});
        cmp_val({7'h0, vbit}, 8'h01);
        cmp_val({7'h0, ebit}, {7'h0, sp});
        @(posedge mclk);
        nrst <= 1'b1;
    endtask
    task endt(input string n);
        $display("test %s finished", n);
    endtask

    initial begin
        #100000;
        failures++;
        summarize();
    end

    initial begin
        do_reset(1'b0);
        endt("reset");
        one(0, 1'b0, 1'b0, 1'b1, EXU_C_DSS);
        one(1, 1'b0, 1'b0, 1'b1, EXU_C_DINT);
        one(2, 1'b0, 1'b0, 1'b1, EXU_C_NMI);
        one(3, 1'b0, 1'b0, 1'b1, EXU_C_MCHECK);
        one(4, 1'b0, 1'b0, 1'b1, EXU_C_IBRK);
        one(5, 1'b0, 1'b0, 1'b1, EXU_C_IWATCH);
        one(6, 1'b0, 1'b0, 1'b1, EXU_C_FETCH_ALIGN);
        one(7, 1'b0, 1'b0, 1'b1, EXU_C_FETCH_PROT);
        one(8, 1'b0, 1'b0, 1'b1, EXU_C_FETCH_MISS);
        one(9, 1'b0, 1'b0, 1'b1, EXU_C_FETCH_INV);
        one(10, 1'b0, 1'b0, 1'b1, EXU_C_FETCH_BUS);
        one(11, 1'b0, 1'b0, 1'b1, EXU_C_DBG_BRK);
        one(12, 1'b0, 1'b0, 1'b1, EXU_C_SYSTRAP);
        one(13, 1'b0, 1'b0, 1'b1, EXU_C_BREAK);
        one(14, 1'b0, 1'b0, 1'b1, EXU_C_RSVD);
        one(15, 1'b0, 1'b0, 1'b1, EXU_C_COP_UNUSE);
        one(16, 1'b0, 1'b0, 1'b1, EXU_C_OVF);
        one(17, 1'b0, 1'b0, 1'b1, EXU_C_TRAP);
        one(18, 1'b1, 1'b0, 1'b1, EXU_C_DADDR_BRK);
        one(19, 1'b0, 1'b1, 1'b1, EXU_C_DADDR_BRK);
        one(20, 1'b1, 1'b0, 1'b1, EXU_C_DWATCH);
        one(21, 1'b1, 1'b0, 1'b1, EXU_C_LD_ALIGN);
        one(22, 1'b1, 1'b0, 1'b1, EXU_C_LD_PROT);
        one(21, 1'b0, 1'b1, 1'b1, EXU_C_ST_ALIGN);
        one(22, 1'b0, 1'b1, 1'b1, EXU_C_ST_PROT);
        one(23, 1'b1, 1'b0, 1'b1, EXU_C_LD_MISS);
        one(24, 1'b1, 1'b0, 1'b1, EXU_C_LD_INV);
        one(23, 1'b0, 1'b1, 1'b1, EXU_C_ST_MISS);
        one(24, 1'b0, 1'b1, 1'b1, EXU_C_ST_INV);
        one(27, 1'b0, 1'b1, 1'b0, EXU_C_WPROT);
        one(27, 1'b0, 1'b1, 1'b1, EXU_C_NONE);
        one(25, 1'b1, 1'b0, 1'b1, EXU_C_DBUS);
        one(26, 1'b1, 1'b0, 1'b1, EXU_C_LD_DATA_BRK);
        endt("causes");
        @(posedge mclk);
        cond <= 27'h20;
        wm <= 1'b1;
        go();
        cmp_cause(EXU_C_NONE);
        cmp_val({7'h0, watch_deferred}, 8'h01);
        @(posedge mclk);
        cond <= 27'h0;
        go();
        cmp_cause(EXU_C_NONE);
        @(posedge mclk);
        wm <= 1'b0;
        go();
        cmp_cause(EXU_C_DEF_WATCH);
        cmp_val({7'h0, watch_deferred}, 8'h00);
        go();
        cmp_cause(EXU_C_NONE);
        endt("deferred watch");
        @(posedge mclk);
        msk <= 9'h1FF;
        gen <= 1'b1;
        irq(2'h1, 1'b0, 6'h00, EXU_C_INT, 8'h00);
        cmp_val({7'h0, irq_vectored}, 8'h00);
        @(posedge mclk);
        gen <= 1'b0;
        irq(2'h2, 1'b0, 6'h00, EXU_C_NONE, 8'h00);
        @(posedge mclk);
        gen <= 1'b1;
        msk <= 9'h1FD;
        irq(2'h2, 1'b0, 6'h00, EXU_C_NONE, 8'h00);
        set_mode(2'h1, EXU_MODE_VECTORED);
        irq(2'h0, 1'b0, 6'h01, EXU_C_INT, 8'h43);
        irq(2'h1, 1'b0, 6'h20, EXU_C_INT, 8'h58);
        irq(2'h0, 1'b1, 6'h00, EXU_C_INT, 8'h72);
        @(posedge mclk);
        msk <= 9'h0FF;
        irq(2'h1, 1'b0, 6'h20, EXU_C_INT, 8'h50);
        set_mode(2'h3, EXU_MODE_VECTORED);
        set_mode(2'h2, EXU_MODE_VECTORED);
        set_mode(2'h0, EXU_MODE_COMPAT);
        set_mode(2'h1, EXU_MODE_VECTORED);
        irq(2'h0, 1'b0, 6'h00, EXU_C_NONE, 8'h00);
        endt("interrupt modes");
        do_reset(1'b1);
        set_mode(2'h2, EXU_MODE_EXTERNAL);
        irq(2'h0, 1'b0, 6'h01, EXU_C_NONE, 8'h00);
        @(posedge mclk);
        raise <= 1'b1;
        evec <= 4'hA;
        eshd <= 2'h2;
        go();
        cmp_cause(EXU_C_INT);
        cmp_val({1'b0, irq_vectored, irq_shadow, irq_vector}, 8'h6A);
        @(posedge mclk);
        raise <= 1'b0;
        go();
        cmp_cause(EXU_C_NONE);
        endt("external controller");
        summarize();
    end
endmodule
